// ### include/rmms_defines.svh
/*
 holds the offsets, field codes, reset values and limits of the
 run mode monitor selector.
 assumes it is included by bare name wherever these are needed.
*/
`ifndef RMMS_DEFINES_SVH
`define RMMS_DEFINES_SVH
// register byte offsets
`define RMMS_OFS_MON 8'h00
`define RMMS_OFS_SUB 8'h04
`define RMMS_OFS_SCALE 8'h08
`define RMMS_OFS_FEED 8'h0C
`define RMMS_OFS_COEF_A 8'h10
`define RMMS_OFS_COEF_B 8'h14
`define RMMS_OFS_PID 8'h18
`define RMMS_OFS_TMR 8'h1C
`define RMMS_OFS_FSRC 8'h20
`define RMMS_OFS_STAT 8'h24
`define RMMS_OFS_DISP 8'h28
// monitor item codes
`define RMMS_MON_SPEED 4'h0
`define RMMS_MON_CURR 4'h3
`define RMMS_MON_VOLT 4'h4
`define RMMS_MON_POWER 4'h9
`define RMMS_MON_PIDCMD 4'hA
`define RMMS_MON_PIDFB 4'hC
`define RMMS_MON_TIMER 4'hD
`define RMMS_ITEM_LAST 3'h6
// speed sub-item codes
`define RMMS_SUB_RAW 3'h0
`define RMMS_SUB_COMP 3'h1
`define RMMS_SUB_REF 3'h2
`define RMMS_SUB_SHAFT 3'h4
`define RMMS_SUB_LINE 3'h5
`define RMMS_SUB_FEED 3'h6
// mode codes
`define RMMS_PID_PROC1 2'h1
`define RMMS_PID_PROC2 2'h2
`define RMMS_TMR_ON 1'h1
`define RMMS_FSRC_KNOB 3'h4
// reset values
`define RMMS_RST_MON 4'h0
`define RMMS_RST_SUB 3'h0
`define RMMS_RST_SCALE 16'h0001
`define RMMS_RST_FEED 16'h0001
`define RMMS_RST_COEF_A 16'h0064
`define RMMS_RST_COEF_B 16'h0000
`define RMMS_RST_PID 2'h0
`define RMMS_RST_TMR 1'h0
`define RMMS_RST_FSRC 3'h4
// display limit and bus answers
`define RMMS_OVF_LIMIT 32'h0000_2710
`define RMMS_RESP_OKAY 2'h0
`define RMMS_RESP_SLVERR 2'h2
`endif

// ### include/rmms_pkg.sv
/*
 holds the types of the run mode monitor selector.
 assumes nothing beyond a SystemVerilog compiler.
*/
package rmms_pkg;
  // one-hot top states
  typedef enum logic [1:0] {
    RMMS_ST_BOOT = 2'h1,
    RMMS_ST_RUN = 2'h2
  } rmms_state_t;

  // whole state of the block
  typedef struct packed {
    rmms_state_t st;
    logic [2:0] item;
    logic fresh;
    logic [3:0] mon_sel;
    logic [2:0] sub_sel;
    logic [15:0] scale;
    logic [15:0] feed;
    logic [15:0] coef_a;
    logic [15:0] coef_b;
    logic [1:0] pid_mode;
    logic tmr_en;
    logic [2:0] fsrc;
    logic aw_ok;
    logic w_ok;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] disp;
    logic dash;
    logic ovf;
    logic dp_blink;
    logic dp_lit;
    logic [15:0] ref_freq;
  } rmms_state_s_t;
endpackage : rmms_pkg

// ### logic/rmms_top.sv
/*
 run mode monitor selector: picks and formats the quantity shown on
 a four-digit monitor, with settings held behind an AXI4-Lite slave.
 assumes measured values arrive as synchronous inputs and the key
 input is a one-cycle pulse per press.
*/
// How it works
// - enters running mode by itself after reset
// - first item comes from stored item setting
// - each key press in running mode advances to next item, unless a legal item write lands that cycle
// - item codes 0,3,4,9,10,12,13
// - pid value times (A minus B) plus B
// - pid items dashed unless pid mode 1/2 and a key was pressed since reset
// - timer item dashed unless timer enabled and a key was pressed since reset
// - pid command blinks lowest decimal point
// - pid feedback lights lowest decimal point
// - timer shows remaining count, positive integer
// - speed sub-item codes 0,1,2,4,5,6
// - shaft and line speed: frequency times coefficient
// - feed time: coefficient over frequency times feed
// - computed speed at 10000 or more: overflow
// - scaled speeds use uncompensated output frequency
// - frequency source 4 takes the knob
`timescale 1ns/100ps
`include "rmms_defines.svh"
module rmms_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // keypad
  input wire logic function_data_key,
  // measured quantities
  input wire logic [15:0] out_freq_raw,
  input wire logic [15:0] out_freq_comp,
  input wire logic [15:0] ref_freq_final,
  input wire logic [15:0] out_current,
  input wire logic [15:0] out_voltage,
  input wire logic [15:0] in_power,
  input wire logic [15:0] pid_command,
  input wire logic [15:0] pid_feedback,
  input wire logic [15:0] timer_remaining,
  input wire logic [15:0] builtin_knob,
  input wire logic [15:0] keypad_freq,
  // monitor outputs
  output logic run_mode,
  output logic [3:0] item_code,
  output logic [31:0] disp_value,
  output logic disp_dashes,
  output logic disp_overflow,
  output logic dp_blink,
  output logic dp_lit,
  output logic [15:0] ref_freq
);
  rmms_pkg::rmms_state_s_t q, n; // state and its next value
  logic aw_hs, w_hs, b_hs, ar_hs, r_hs; // channel handshakes
  logic [3:0] cur_code; // code of the shown item
  logic [31:0] prod_scale, prod_feed, quot; // speed arithmetic
  logic [31:0] spd_val; // selected speed value
  logic spd_ovf; // computed speed too large
  logic [15:0] pid_src; // pid quantity shown
  logic signed [35:0] pid_val; // scaled pid value
  logic [32:0] rd_word; // {error, data} for read
  logic [31:0] mg; // merged write word
  logic [4:0] code_idx; // {legal, index} of written code
  // item index to monitor code
  function automatic logic [3:0] code_of(input logic [2:0] i);
    case (i)
      3'h0: code_of = `RMMS_MON_SPEED;
      3'h1: code_of = `RMMS_MON_CURR;
      3'h2: code_of = `RMMS_MON_VOLT;
      3'h3: code_of = `RMMS_MON_POWER;
      3'h4: code_of = `RMMS_MON_PIDCMD;
      3'h5: code_of = `RMMS_MON_PIDFB;
      default: code_of = `RMMS_MON_TIMER;
    endcase
  endfunction : code_of
  // monitor code to {legal, index}
  function automatic logic [4:0] idx_of(input logic [3:0] c);
    case (c)
      `RMMS_MON_SPEED: idx_of = 5'h10;
      `RMMS_MON_CURR: idx_of = 5'h11;
      `RMMS_MON_VOLT: idx_of = 5'h12;
      `RMMS_MON_POWER: idx_of = 5'h13;
      `RMMS_MON_PIDCMD: idx_of = 5'h14;
      `RMMS_MON_PIDFB: idx_of = 5'h15;
      `RMMS_MON_TIMER: idx_of = 5'h16;
      default: idx_of = 5'h00;
    endcase
  endfunction : idx_of
  // byte-lane merge of a write into a read-map word
  function automatic logic [31:0] merge(input logic [32:0] o,
      input logic [31:0] d, input logic [3:0] s);
    merge = o[31:0];
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        merge[i*8 +: 8] = d[i*8 +: 8];
      end
    end
  endfunction : merge
  // register read map, top bit flags an unmapped address
  function automatic logic [32:0] reg_rd(
      input rmms_pkg::rmms_state_s_t s, input logic [7:0] a);
    case (a)
      `RMMS_OFS_MON: reg_rd = {29'h0, s.mon_sel};
      `RMMS_OFS_SUB: reg_rd = {30'h0, s.sub_sel};
      `RMMS_OFS_SCALE: reg_rd = {17'h0, s.scale};
      `RMMS_OFS_FEED: reg_rd = {17'h0, s.feed};
      `RMMS_OFS_COEF_A: reg_rd = {17'h0, s.coef_a};
      `RMMS_OFS_COEF_B: reg_rd = {17'h0, s.coef_b};
      `RMMS_OFS_PID: reg_rd = {31'h0, s.pid_mode};
      `RMMS_OFS_TMR: reg_rd = {32'h0, s.tmr_en};
      `RMMS_OFS_FSRC: reg_rd = {30'h0, s.fsrc};
      `RMMS_OFS_STAT: reg_rd = {20'h0, s.dp_lit, s.dp_blink, s.ovf,
        s.dash, s.st == rmms_pkg::RMMS_ST_RUN, s.fresh, 3'h0, code_of(s.item)};
      `RMMS_OFS_DISP: reg_rd = {1'h0, s.disp};
      default: reg_rd = {1'h1, 32'h0};
    endcase
  endfunction : reg_rd
  // bus handshakes; one write and one read in flight
  assign s_axi_awready = !q.aw_ok && !q.bvalid;
  assign s_axi_wready = !q.w_ok && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign b_hs = q.bvalid && s_axi_bready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign r_hs = q.rvalid && s_axi_rready;
  assign rd_word = reg_rd(q, s_axi_araddr);
  // speed arithmetic on the uncompensated frequency
  assign cur_code = code_of(q.item);
  assign prod_scale = 32'(out_freq_raw) * 32'(q.scale);
  assign prod_feed = 32'(out_freq_raw) * 32'(q.feed);
  // zero divisor counts as too large
  assign quot = (prod_feed == 32'h0) ? 32'hFFFF_FFFF :
    32'(q.scale) / prod_feed;
  assign pid_src = (cur_code == `RMMS_MON_PIDCMD) ? pid_command : pid_feedback;
  assign pid_val = $signed({20'h0, pid_src}) *
    ($signed({20'h0, q.coef_a}) - $signed({20'h0, q.coef_b})) +
    $signed({20'h0, q.coef_b});
  // speed sub-item select
  always_comb begin
    case (q.sub_sel)
      `RMMS_SUB_COMP: spd_val = 32'(out_freq_comp);
      `RMMS_SUB_REF: spd_val = 32'(ref_freq_final);
      `RMMS_SUB_SHAFT, `RMMS_SUB_LINE: spd_val = prod_scale;
      `RMMS_SUB_FEED: spd_val = quot;
      default: spd_val = 32'(out_freq_raw);
    endcase
    spd_ovf = (q.sub_sel >= `RMMS_SUB_SHAFT) &&
      (spd_val >= `RMMS_OVF_LIMIT);
  end
  // next state
  always_comb begin
    n = q;
    mg = 32'h0;
    code_idx = 5'h0;
    // top state and item stepping
    case (q.st)
      rmms_pkg::RMMS_ST_BOOT: begin
        n.item = 3'(idx_of(q.mon_sel));
        n.st = rmms_pkg::RMMS_ST_RUN;
      end
      rmms_pkg::RMMS_ST_RUN: begin
        if (function_data_key) begin
          n.fresh = 1'h0;
          // step, wrapping after the last
          n.item = (q.item == `RMMS_ITEM_LAST) ? 3'h0 :
            q.item + 3'h1;
        end
      end
      default: n.st = rmms_pkg::RMMS_ST_BOOT;
    endcase
    // write channel capture, either order
    if (aw_hs) begin
      n.aw_ok = 1'h1;
      n.waddr = s_axi_awaddr;
    end
    if (w_hs) begin
      n.w_ok = 1'h1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (b_hs) begin
      n.bvalid = 1'h0;
    end
    // both halves present: perform write
    if (n.aw_ok && n.w_ok) begin
      n.aw_ok = 1'h0;
      n.w_ok = 1'h0;
      n.bvalid = 1'h1;
      n.bresp = `RMMS_RESP_OKAY;
      mg = merge(reg_rd(q, n.waddr), n.wdata, n.wstrb);
      code_idx = idx_of(mg[3:0]);
      case (n.waddr)
        `RMMS_OFS_MON: begin
          // illegal codes are kept out
          if (code_idx[4]) begin
            n.mon_sel = mg[3:0];
            n.item = code_idx[2:0];
          end
        end
        `RMMS_OFS_SUB: begin
          if (mg[2:0] != 3'h3 && mg[2:0] != 3'h7) begin
            n.sub_sel = mg[2:0];
          end
        end
        `RMMS_OFS_SCALE: n.scale = mg[15:0];
        `RMMS_OFS_FEED: n.feed = mg[15:0];
        `RMMS_OFS_COEF_A: n.coef_a = mg[15:0];
        `RMMS_OFS_COEF_B: n.coef_b = mg[15:0];
        `RMMS_OFS_PID: n.pid_mode = mg[1:0];
        `RMMS_OFS_TMR: n.tmr_en = mg[0];
        `RMMS_OFS_FSRC: n.fsrc = mg[2:0];
        // status and display are read only
        `RMMS_OFS_STAT, `RMMS_OFS_DISP: n.bresp = `RMMS_RESP_OKAY;
        default: n.bresp = `RMMS_RESP_SLVERR;
      endcase
    end
    // read channel
    if (r_hs) begin
      n.rvalid = 1'h0;
    end
    if (ar_hs) begin
      n.rvalid = 1'h1;
      n.rdata = rd_word[31:0];
      n.rresp = rd_word[32] ? `RMMS_RESP_SLVERR : `RMMS_RESP_OKAY;
    end
    // display value per item
    n.ovf = 1'h0;
    n.dash = 1'h0;
    case (cur_code)
      `RMMS_MON_SPEED: begin
        n.disp = spd_val;
        n.ovf = spd_ovf;
      end
      `RMMS_MON_CURR: n.disp = 32'(out_current);
      `RMMS_MON_VOLT: n.disp = 32'(out_voltage);
      `RMMS_MON_POWER: n.disp = 32'(in_power);
      `RMMS_MON_PIDCMD, `RMMS_MON_PIDFB: begin
        n.disp = pid_val[31:0];
        n.dash = q.fresh || (q.pid_mode != `RMMS_PID_PROC1 &&
          q.pid_mode != `RMMS_PID_PROC2);
      end
      default: begin
        n.disp = 32'(timer_remaining);
        n.dash = q.fresh || (q.tmr_en != `RMMS_TMR_ON);
      end
    endcase
    n.dp_blink = (cur_code == `RMMS_MON_PIDCMD) && !n.dash;
    n.dp_lit = (cur_code == `RMMS_MON_PIDFB) && !n.dash;
    n.ref_freq = (q.fsrc == `RMMS_FSRC_KNOB) ? builtin_knob :
      keypad_freq;
  end
  // state register, synchronous reset
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      q <= '{st: rmms_pkg::RMMS_ST_BOOT, item: 3'h0, fresh: 1'h1,
        mon_sel: `RMMS_RST_MON, sub_sel: `RMMS_RST_SUB,
        scale: `RMMS_RST_SCALE, feed: `RMMS_RST_FEED,
        coef_a: `RMMS_RST_COEF_A, coef_b: `RMMS_RST_COEF_B,
        pid_mode: `RMMS_RST_PID, tmr_en: `RMMS_RST_TMR,
        fsrc: `RMMS_RST_FSRC, bresp: `RMMS_RESP_OKAY,
        rresp: `RMMS_RESP_OKAY, default: '0};
    end else begin
      q <= n;
    end
  end
  // outputs straight from state
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign run_mode = (q.st == rmms_pkg::RMMS_ST_RUN);
  assign item_code = cur_code;
  assign disp_value = q.disp;
  assign disp_dashes = q.dash;
  assign disp_overflow = q.ovf;
  assign dp_blink = q.dp_blink;
  assign dp_lit = q.dp_lit;
  assign ref_freq = q.ref_freq;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_key_step;
    run_mode && function_data_key && !(q.aw_ok || aw_hs);
  endsequence
  sequence s_pid_off;
    (cur_code == `RMMS_MON_PIDCMD || cur_code == `RMMS_MON_PIDFB) &&
      q.pid_mode != 2'h1 && q.pid_mode != 2'h2;
  endsequence

  a_boot_run: assert property (resetn && !run_mode |=> run_mode ##1 run_mode)
    else $error("no running mode after reset");
  a_boot_item: assert property (!run_mode |=> item_code == $past(q.mon_sel))
    else $error("first item not from setting");
  a_key_step: assert property (s_key_step ##0 q.item != 3'h6 |=>
    q.item == $past(q.item) + 3'h1) else $error("key did not advance");
  a_key_wrap: assert property (s_key_step ##0 q.item == 3'h6 |=>
    q.item == 3'h0) else $error("key did not wrap");
  a_pid_dash: assert property (s_pid_off |=> disp_dashes && !dp_blink)
    else $error("pid item shown while off");
  a_tmr_dash: assert property (cur_code == 4'hD && !q.tmr_en |=> disp_dashes)
    else $error("timer shown while off");
  a_pid_blink: assert property (cur_code == 4'hA && !q.fresh &&
    q.pid_mode inside {2'h1, 2'h2} |=> dp_blink && !dp_lit) else $error("no blink");
  a_pid_lit: assert property (cur_code == 4'hC && !q.fresh &&
    q.pid_mode inside {2'h1, 2'h2} |=> dp_lit && !dp_blink) else $error("no lit point");
  a_spd_ovf: assert property (cur_code == 4'h0 && q.sub_sel inside {3'h4, 3'h5} &&
    prod_scale >= 32'h0000_2710 |=> disp_overflow) else $error("no overflow");
  a_spd_scale: assert property (cur_code == 4'h0 && q.sub_sel == 3'h5 |=>
    disp_value == $past(out_freq_raw) * $past(q.scale)) else $error("bad scale");
  a_knob_src: assert property (resetn && q.fsrc == 3'h4 |=>
    ref_freq == $past(builtin_knob)) else $error("knob not selected");
  a_wr_resp: assert property ((q.aw_ok || aw_hs) && w_hs && !q.bvalid |=> s_axi_bvalid)
    else $error("write not answered");
endmodule : rmms_top

// ### verif/rmms_keypad_model.sv
/*
 keypad model: presses the function/data key when the bench asks.
 assumes the bench calls tap from its main sequence.
*/
`timescale 1ns/100ps
module rmms_keypad_model (
  // clock
  input wire logic core_clk,
  // key line to the block
  output logic function_data_key
);
  // key rests released
  initial function_data_key = 1'b0;

  // one-cycle press, launched just after an edge
  task automatic tap();
    @(posedge core_clk);
    function_data_key <= 1'b1;
    @(posedge core_clk);
    function_data_key <= 1'b0;
  endtask : tap
endmodule : rmms_keypad_model

// ### verif/testbench.sv
/*
 self-checking bench: settings over axi4-lite, keypad via model.
 assumes the run mode monitor selector and its keypad model.
*/
`timescale 1ns/100ps
module testbench;
  // clock, reset, tallies
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  // bus master side
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, got;
  // measured quantities
  logic [15:0] f_raw = 16'h0032;
  logic [15:0] f_comp = 16'h0030;
  logic [15:0] f_ref = 16'h0034;
  logic [15:0] cur = 16'h0013;
  logic [15:0] volt = 16'h00C8;
  logic [15:0] pwr = 16'h0192;
  logic [15:0] pcmd = 16'h0007;
  logic [15:0] pfb = 16'h0009;
  logic [15:0] tmr = 16'h0005;
  logic [15:0] knob = 16'h0111;
  logic [15:0] kfreq = 16'h0222;
  // monitor outputs
  logic run_mode, dashes, ovf, blink, lit, key;
  logic [3:0] item_code;
  logic [31:0] disp_value;
  logic [15:0] ref_freq;
  // tables
  logic [7:0] ofs [9];
  logic [31:0] rst [9];
  logic [3:0] code [7];
  logic [31:0] ev [7];
  logic [3:0] fl [7];
  logic [2:0] sc [6];

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  rmms_top uut (
    .core_clk(core_clk), .resetn(resetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .function_data_key(key),
    .out_freq_raw(f_raw), .out_freq_comp(f_comp), .ref_freq_final(f_ref),
    .out_current(cur), .out_voltage(volt), .in_power(pwr),
    .pid_command(pcmd), .pid_feedback(pfb), .timer_remaining(tmr),
    .builtin_knob(knob), .keypad_freq(kfreq), .run_mode(run_mode),
    .item_code(item_code), .disp_value(disp_value), .disp_dashes(dashes),
    .disp_overflow(ovf), .dp_blink(blink), .dp_lit(lit), .ref_freq(ref_freq)
  );

  // keypad on the far side
  rmms_keypad_model kp (.core_clk(core_clk), .function_data_key(key));

  // verdict and end of run
  task automatic close_out();
    if (mismatches == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      close_out();
    end
  end

  // compare one value
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // one write; ready is read mid-cycle, the edge after takes it
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_t, w_t, b_t;
    b_t = 1'b0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_t) begin
      @(negedge core_clk);
      aw_t = awvalid & awready;
      w_t = wvalid & wready;
      b_t = bready & bvalid;
      resp = bresp;
      @(posedge core_clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) bready <= 1'b0;
    end
  endtask : axi_wr

  // one read
  task automatic axi_rd(input logic [7:0] a);
    logic ar_t, r_t;
    r_t = 1'b0;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_t) begin
      @(negedge core_clk);
      ar_t = arvalid & arready;
      r_t = rready & rvalid;
      got = rdata;
      resp = rresp;
      @(posedge core_clk);
      if (ar_t) arvalid <= 1'b0;
      if (r_t) rready <= 1'b0;
    end
  endtask : axi_rd

  // let the display settle, then check {dash,ovf,blink,lit} and, unless dash or ovf is expected, the value
  task automatic look(input logic [31:0] v, input logic [3:0] f);
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    if (!f[3] && !f[2]) chk("disp value", v, disp_value);
    chk("disp flags", {28'h0, f}, {28'h0, dashes, ovf, blink, lit});
  endtask : look

  // main sequence
  initial begin
    ofs = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
    rst = '{32'h0, 32'h0, 32'h1, 32'h1, 32'h64, 32'h0, 32'h0, 32'h0, 32'h4};
    code = '{4'h3, 4'h4, 4'h9, 4'hA, 4'hC, 4'hD, 4'h0};
    fl = '{4'h0, 4'h0, 4'h0, 4'h2, 4'h1, 4'h8, 4'h0};
    sc = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h3};
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    chk("run mode", 32'h1, {31'h0, run_mode});
    chk("item code", 32'h0, {28'h0, item_code});
    chk("ref freq", {16'h0, knob}, {16'h0, ref_freq});
    for (int i = 0; i < 9; i++) begin
      axi_rd(ofs[i]);
      chk("reset value", rst[i], got);
    end
    axi_rd(8'h2C);
    chk("unmapped read", 32'h2, {30'h0, resp});
    axi_wr(8'h30, 32'h1);
    chk("unmapped write", 32'h2, {30'h0, resp});
    // pid enabled but no key yet: still dashed
    axi_wr(8'h18, 32'h1);
    axi_wr(8'h00, 32'hA);
    look(32'h0, 4'h8);
    // walk all items with the key, wrapping back to speed
    axi_wr(8'h00, 32'h0);
    ev = '{{16'h0, cur}, {16'h0, volt}, {16'h0, pwr}, {16'h0, pcmd} * 32'h64,
           {16'h0, pfb} * 32'h64, 32'h0, {16'h0, f_raw}};
    for (int i = 0; i < 7; i++) begin
      kp.tap();
      look(ev[i], fl[i]);
      chk("item code", {28'h0, code[i]}, {28'h0, item_code});
    end
    // pid scaling with a nonzero offset
    axi_wr(8'h14, 32'h5);
    axi_wr(8'h18, 32'h2);
    @(posedge core_clk);
    pcmd <= 16'h000B;
    axi_wr(8'h00, 32'hA);
    look(32'h41A, 4'h2);
    axi_wr(8'h18, 32'h3);
    look(32'h0, 4'h8);
    // timer enabled
    axi_wr(8'h1C, 32'h1);
    axi_wr(8'h00, 32'hD);
    look({16'h0, tmr}, 4'h0);
    // speed sub-items; code 3 is refused and 5 is kept
    axi_wr(8'h00, 32'h0);
    axi_wr(8'h08, 32'h3);
    ev = '{{16'h0, f_raw}, {16'h0, f_comp}, {16'h0, f_ref}, {16'h0, f_raw} * 32'h3,
           {16'h0, f_raw} * 32'h3, {16'h0, f_raw} * 32'h3, 32'h0};
    for (int i = 0; i < 6; i++) begin
      axi_wr(8'h04, {29'h0, sc[i]});
      look(ev[i], 4'h0);
    end
    // overflow boundary just below and at the limit
    axi_wr(8'h08, 32'hC7);
    look({16'h0, f_raw} * 32'hC7, 4'h0);
    axi_wr(8'h08, 32'hC8);
    look(32'h0, 4'h4);
    // feeding time
    @(posedge core_clk);
    f_raw <= 16'h0019;
    axi_wr(8'h08, 32'h3E8);
    axi_wr(8'h0C, 32'h2);
    axi_wr(8'h04, 32'h6);
    look(32'h14, 4'h0);
    // keypad as frequency source
    axi_wr(8'h20, 32'h0);
    look(32'h14, 4'h0);
    chk("ref freq", {16'h0, kfreq}, {16'h0, ref_freq});
    axi_rd(8'h28);
    chk("disp reg", 32'h14, got);
    close_out();
  end
endmodule : testbench
